// ==== shared/lcp_defs.vh ====
// Constants for the display clock and ladder power controller.
// Assumes a single 25 MHz clock domain and a plain register port.
`ifndef LCP_DEFS_VH
`define LCP_DEFS_VH

`define LCP_ADDR_W          4
`define LCP_OFF_CLKCFG      4'h0
`define LCP_OFF_BIASCFG     4'h1
`define LCP_OFF_LADDER      4'h2
`define LCP_OFF_STATUS      4'h3

`define LCP_SRC_SYSDIV      2'h0
`define LCP_SRC_CRYSTAL     2'h1
`define LCP_SRC_LFOSC       2'h2

`define LCP_CLK_SRC_LSB     0
`define LCP_CLK_PRE_LSB     2
`define LCP_CLK_XEN_BIT     6
`define LCP_CLK_ACT_BIT     7

`define LCP_BIAS_HALF_BIT   0
`define LCP_BIAS_STATIC_BIT 1
`define LCP_BIAS_LADEN_BIT  2

`define LCP_LAD_A_LSB       6
`define LCP_LAD_B_LSB       4
`define LCP_LAD_T_LSB       0
`define LCP_LAD_WMASK       8'hF7

`define LCP_PWR_OFF         2'h0
`define LCP_PWR_LOW         2'h1
`define LCP_PWR_MED         2'h2
`define LCP_PWR_HIGH        2'h3

`define LCP_RST_CLKCFG      8'h00
`define LCP_RST_BIASCFG     8'h00
`define LCP_RST_LADDER      8'h00

`define LCP_SYSDIV_RATIO    256
`define LCP_SYSDIV_W        8
`define LCP_BASE_DIV        32
`define LCP_BASE_W          5

`endif

// ==== rtl/lcp_tick_div.v ====
// Free-running tick divider: one-cycle tick every RATIO enabled input ticks.
// Assumes the ratio is fixed at build time and not software visible.
`timescale 1ns/1ns
module lcp_tick_div #(
    parameter W     = 8,
    parameter RATIO = 256
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire         in_tick,
    output reg          out_tick,
    output wire [W-1:0] phase
);
    localparam integer LAST_I = RATIO - 1;
    localparam [W-1:0] LAST   = LAST_I[W-1:0];
    reg [W-1:0] cnt_r;
    assign phase = cnt_r;
    always @(posedge clk) begin
        if (rst) begin
            cnt_r    <= {W{1'b0}};
            out_tick <= 1'b0;
        end else if (ce) begin
            out_tick <= 1'b0;
            if (in_tick) begin
                if (cnt_r == LAST) begin
                    cnt_r    <= {W{1'b0}};
                    out_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

// ==== rtl/lcp_prescaler.v ====
// Frame prescaler: divides source ticks by select+1, 1:1 through 1:16.
// The count is internal only; software sees just the ratio setting.
`timescale 1ns/1ns
module lcp_prescaler (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       in_tick,
    input  wire [3:0] ratio_sel,
    output reg        out_tick
);
    reg [3:0] cnt_r;
    always @(posedge clk) begin
        if (rst) begin
            cnt_r    <= 4'h0;
            out_tick <= 1'b0;
        end else if (ce) begin
            out_tick <= 1'b0;
            if (in_tick) begin
                if (cnt_r >= ratio_sel) begin
                    cnt_r    <= 4'h0;
                    out_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule

// ==== rtl/lcp_top.v ====
// Top of the display clock and reference ladder power controller.
// Assumes oscillator ticks arrive as one-cycle pulses synchronous to clk.
`timescale 1ns/1ns
`include "lcp_defs.vh"
module lcp_top (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       core_sleep,
    input  wire       crystal_osc_tick,
    input  wire       low_freq_osc_tick,
    input  wire       seg_transition,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    output reg        frame_tick,
    output reg        crystal_osc_enable,
    output reg  [1:0] ladder_power,
    output reg        ladder_connect,
    output reg        ladder_mid_short,
    output reg        bias_static,
    output reg        display_active
);
    reg  [7:0] clkcfg_r;
    reg  [7:0] biascfg_r;
    reg  [7:0] ladder_r;
    reg        in_a_r;
    reg  [2:0] a_cnt_r;
    reg        src_tick;
    wire       sysdiv_tick;
    wire       pre_tick;
    wire       base_tick;
    wire       base_wrap;
    reg  [1:0] power_nxt;
    reg  [7:0] rdata_nxt;
    reg        a_state_nxt;
    reg  [2:0] a_cnt_nxt;

    wire [1:0] src_sel  = clkcfg_r[`LCP_CLK_SRC_LSB +: 2];
    wire [3:0] pre_sel  = clkcfg_r[`LCP_CLK_PRE_LSB +: 4];
    wire       act_bit  = clkcfg_r[`LCP_CLK_ACT_BIT];
    wire [1:0] mode_a   = ladder_r[`LCP_LAD_A_LSB +: 2];
    wire [1:0] mode_b   = ladder_r[`LCP_LAD_B_LSB +: 2];
    wire [2:0] a_len    = ladder_r[`LCP_LAD_T_LSB +: 3];
    wire       half_bias   = biascfg_r[`LCP_BIAS_HALF_BIT];
    wire       static_bias = biascfg_r[`LCP_BIAS_STATIC_BIT];
    wire       ladder_en   = biascfg_r[`LCP_BIAS_LADEN_BIT];
    // The system clock source stops in sleep; oscillator sources do not.
    wire       sys_run  = ~core_sleep;

    // Fixed 256 divider, no register reaches its ratio.
    lcp_tick_div #(
        .W     (`LCP_SYSDIV_W),
        .RATIO (`LCP_SYSDIV_RATIO)
    ) u_sysdiv (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .in_tick  (sys_run),
        .out_tick (sysdiv_tick),
        .phase    ()
    );

    always @* begin
        case (src_sel)
            `LCP_SRC_SYSDIV:  src_tick = sysdiv_tick;
            `LCP_SRC_CRYSTAL: src_tick = crystal_osc_tick & crystal_osc_enable;
            `LCP_SRC_LFOSC:   src_tick = low_freq_osc_tick;
            default:          src_tick = 1'b0;
        endcase
    end

    lcp_prescaler u_pre (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_tick   (src_tick & act_bit),
        .ratio_sel (pre_sel),
        .out_tick  (pre_tick)
    );

    // Base-rate divider of the 32 kHz clock; base_wrap drives nothing, and the A interval counts undivided base_tick.
    lcp_tick_div #(
        .W     (`LCP_BASE_W),
        .RATIO (`LCP_BASE_DIV)
    ) u_base (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .in_tick  (crystal_osc_tick | low_freq_osc_tick),
        .out_tick (base_wrap),
        .phase    ()
    );
    assign base_tick = crystal_osc_tick | low_freq_osc_tick;

    // Write strobes, one per register; ce low freezes every register.
    wire       wr_clkcfg  = ce && wr && (addr == `LCP_OFF_CLKCFG);
    wire       wr_biascfg = ce && wr && (addr == `LCP_OFF_BIASCFG);
    wire       wr_ladder  = ce && wr && (addr == `LCP_OFF_LADDER);
    localparam [7:0] LAD_WMASK = `LCP_LAD_WMASK;

    always @(posedge clk) begin
        if (rst) begin
            clkcfg_r <= `LCP_RST_CLKCFG;
        end else if (wr_clkcfg) begin
            clkcfg_r <= wdata;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            biascfg_r <= `LCP_RST_BIASCFG;
        end else if (wr_biascfg) begin
            biascfg_r <= {5'h00, wdata[2:0]};
        end
    end

    // Bit 3 has no storage, so it can never read back as one.
    always @(posedge clk) begin
        if (rst) begin
            ladder_r <= `LCP_RST_LADDER;
        end else if (wr_ladder) begin
            ladder_r <= wdata & LAD_WMASK;
        end
    end

    // Status shows the live interval state so software can see A and B.
    wire [7:0] status_word = {4'h0, in_a_r, display_active, ladder_power};

    // Only the prescale ratio field is visible; the count never is.
    always @* begin
        rdata_nxt = 8'h00;
        if (rd) begin
            case (addr)
                `LCP_OFF_CLKCFG:  rdata_nxt = clkcfg_r;
                `LCP_OFF_BIASCFG: rdata_nxt = biascfg_r;
                `LCP_OFF_LADDER:  rdata_nxt = ladder_r;
                `LCP_OFF_STATUS:  rdata_nxt = status_word;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data stand one cycle only and are zero otherwise.
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rdata_nxt;
        end
    end

    // Interval A state: restarted by each transition unless the A length is zero, counts 32 kHz ticks.
    // A transition inside A restarts the count, so A is never cut short.
    localparam [0:0] ST_MODE_B = 1'b0;
    localparam [0:0] ST_MODE_A = 1'b1;

    always @* begin
        a_state_nxt = in_a_r;
        a_cnt_nxt   = a_cnt_r;
        case (in_a_r)
            ST_MODE_B: begin
                a_state_nxt = ST_MODE_B;
            end
            ST_MODE_A: begin
                if (base_tick) begin
                    if (a_cnt_r + 3'h1 >= a_len) begin
                        a_state_nxt = ST_MODE_B;
                    end else begin
                        a_cnt_nxt = a_cnt_r + 3'h1;
                    end
                end
            end
            default: begin
                a_state_nxt = ST_MODE_B;
            end
        endcase
        if (seg_transition) begin
            a_state_nxt = (a_len != 3'h0) ? ST_MODE_A : ST_MODE_B;
            a_cnt_nxt   = 3'h0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            in_a_r  <= ST_MODE_B;
            a_cnt_r <= 3'h0;
        end else if (ce) begin
            in_a_r  <= a_state_nxt;
            a_cnt_r <= a_cnt_nxt;
        end
    end

    // The ladder is off unless the display runs and the internal ladder is on.
    always @* begin
        case ({act_bit, ladder_en})
            2'b11: begin
                power_nxt = in_a_r ? mode_a : mode_b;
            end
            default: begin
                power_nxt = `LCP_PWR_OFF;
            end
        endcase
    end

    // Outputs, each from a flip-flop.
    always @(posedge clk) begin
        if (rst) begin
            frame_tick <= 1'b0;
        end else if (ce) begin
            frame_tick <= pre_tick;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            crystal_osc_enable <= 1'b0;
        end else if (ce) begin
            crystal_osc_enable <= clkcfg_r[`LCP_CLK_XEN_BIT];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ladder_power <= `LCP_PWR_OFF;
        end else if (ce) begin
            ladder_power <= power_nxt;
        end
    end

    // Connect follows the same next value, so it never lags the power mode.
    always @(posedge clk) begin
        if (rst) begin
            ladder_connect <= 1'b0;
        end else if (ce) begin
            ladder_connect <= (power_nxt != `LCP_PWR_OFF);
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ladder_mid_short <= 1'b0;
        end else if (ce) begin
            ladder_mid_short <= half_bias;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            bias_static <= 1'b0;
        end else if (ce) begin
            bias_static <= static_bias;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            display_active <= 1'b0;
        end else if (ce) begin
            display_active <= act_bit;
        end
    end
endmodule

// ==== verif/lcp_assertions.sv ====
// Port checker for the display clock and ladder power controller.
// Assumes the register port and outputs of lcp_top, one clock domain.
`timescale 1ns/1ns
module lcp_chk (
    input wire       clk,
    input wire       rst,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       frame_tick,
    input wire       crystal_osc_enable,
    input wire [1:0] ladder_power,
    input wire       ladder_connect,
    input wire       ladder_mid_short,
    input wire       display_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_conn_follows_power: assert property (
        ladder_connect == (ladder_power != 2'h0)) else $error("connect mismatch");
    a_idle_ladder_off: assert property (
        !display_active [*2] |-> ladder_power == 2'h0) else $error("ladder on");
    a_idle_no_frame: assert property (
        !display_active [*3] |-> !frame_tick) else $error("frame while idle");
    a_ladder_bit3: assert property (
        $past(rd) && $past(addr) == 4'h2 |-> !rdata[3]) else $error("bit3 set");
    a_bias_upper_zero: assert property (
        $past(rd) && $past(addr) == 4'h1 |-> rdata[7:3] == 5'h00) else $error("bias bits");
    a_unmapped_zero: assert property (
        $past(rd) && $past(addr) > 4'h3 |-> rdata == 8'h00) else $error("unmapped read");
    a_rdata_idle_zero: assert property (
        !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
    a_half_bias_out: assert property (
        wr && addr == 4'h1 |=> ##1 ladder_mid_short == $past(wdata[0], 2))
        else $error("mid short");
    a_xtal_enable_out: assert property (
        wr && addr == 4'h0 |=> ##1 crystal_osc_enable == $past(wdata[6], 2))
        else $error("crystal enable");
endmodule

bind lcp_top lcp_chk u_chk (.*);

// ==== verif/lcp_glass.sv ====
// Far-side model: oscillator pulses that the glass side runs on.
// Assumes one clk; oscillators run free, also through reset and sleep.
`timescale 1ns/1ns
module lcp_glass (
    input  wire  clk,
    output logic crystal_osc_tick,
    output logic low_freq_osc_tick
);
    logic [2:0] cnt_r = 3'h0;
    always @(posedge clk) begin
        cnt_r <= cnt_r + 3'h1;
    end
    // Different rates make the chosen source visible at the frame output.
    assign crystal_osc_tick  = (cnt_r == 3'h5);
    assign low_freq_osc_tick = (cnt_r[1:0] == 2'h1);
endmodule

// ==== verif/test_lcp_top.sv ====
// Self-checking bench for the display clock and ladder power controller.
// Assumes lcp_top and lcp_glass; ce is held high all run.
`timescale 1ns/1ns
`include "lcp_defs.vh"
module test_lcp_top;
    logic       clk = 0, rst = 1, ce = 1, core_sleep = 0;
    logic       seg_transition = 0, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, v;
    wire        crystal_osc_tick, low_freq_osc_tick, frame_tick, crystal_osc_enable;
    wire        ladder_connect, ladder_mid_short, bias_static, display_active;
    wire  [1:0] ladder_power;
    wire  [7:0] rdata;
    integer     error_cnt = 0, checks = 0, seed = 32'h34fb, i, n;
    lcp_top   u_dut (.*);
    lcp_glass u_glass (.*);
    always #20 clk = ~clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    // Frame counts allow one tick of slack for the prescaler's start phase.
    task frames(input logic [7:0] cfg, input logic s, input integer e);
        @(posedge clk);
        core_sleep <= s;
        wreg(`LCP_OFF_CLKCFG, cfg);
        n = 0;
        repeat (1024) @(negedge clk) n = n + frame_tick;
        chk({7'h0, n >= e - 1 && n <= e + 1}, 8'h01);
    endtask
    task pulse;
        @(posedge clk);
        seg_transition <= 1'b1;
        @(posedge clk);
        seg_transition <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) rreg(i[3:0], 8'h00);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            wreg(`LCP_OFF_LADDER, v);
            rreg(`LCP_OFF_LADDER, v & 8'hF7);
            wreg(`LCP_OFF_BIASCFG, v);
            rreg(`LCP_OFF_BIASCFG, v & 8'h07);
            chk({6'h0, bias_static, ladder_mid_short}, {6'h0, v[1:0]});
            wreg(4'h9, v);
            rreg(4'h9, 8'h00);
        end
        wreg(`LCP_OFF_CLKCFG, 8'h82);
        wreg(`LCP_OFF_BIASCFG, 8'h04);
        for (i = 0; i < 2; i++) begin
            wreg(`LCP_OFF_LADDER, i ? 8'hD0 : 8'hD3);
            pulse;
            chk(ladder_power, i ? 8'h01 : 8'h03);
            repeat (20) @(negedge clk);
            chk({ladder_connect, ladder_power}, 8'h05);
            rreg(`LCP_OFF_STATUS, 8'h05);
        end
        wreg(`LCP_OFF_CLKCFG, 8'h02);
        repeat (3) @(negedge clk);
        chk(ladder_power, 8'h00);
        rreg(`LCP_OFF_STATUS, 8'h00);
        wreg(`LCP_OFF_CLKCFG, 8'h82);
        wreg(`LCP_OFF_BIASCFG, 8'h00);
        pulse;
        chk({ladder_connect, ladder_power}, 8'h00);
        frames(8'h82, 0, 256);
        frames(8'h8E, 0, 64);
        frames(8'hBE, 0, 16);
        frames(8'h80, 0, 4);
        frames(8'h80, 1, 0);
        frames(8'h82, 1, 256);
        frames(8'h81, 0, 0);
        frames(8'hC1, 0, 128);
        chk(crystal_osc_enable, 8'h01);
        complete_run;
    end
endmodule
